// ==== crpc_partner.sv ====
// crpc_partner: external reset circuit and oscillator start-up seen by the controller
// assumes: aclk stands in for the oscillator; pin_req models a press on the reset pin
`timescale 1ns/100ps
module crpc_partner #(
  parameter int STAB = 16
) (
  input  wire logic aclk,
  input  wire logic osc_enable,
  input  wire logic pin_req,
  output logic      reset_pin_low,
  output logic      bt_stable_done
);
  int hold_cnt = 0;
  int osc_cnt  = 0;
  // count the hold after power-up or a press, and the start-up after the oscillator runs
  always @(posedge aclk) begin
    hold_cnt <= pin_req ? 0 : (hold_cnt < STAB ? hold_cnt + 1 : hold_cnt);
    osc_cnt  <= (osc_enable !== 1'b1) ? 0 : (osc_cnt < STAB ? osc_cnt + 1 : osc_cnt);
  end
  // pin stays low for STAB cycles after power-up or the end of a press
  assign reset_pin_low  = (hold_cnt >= STAB);
  assign bt_stable_done = (osc_cnt >= STAB);
endmodule

// ==== crpc_pkg.sv ====
// crpc_pkg: constants for the clock, reset and power-down controller
// assumes: included before crpc_top and crpc_sync; 100 MHz aclk
package crpc_pkg;
  // register byte addresses (printed offsets are multiples of four)
  localparam logic [7:0] ADDR_CLK_CTRL   = 8'hD4;
  localparam logic [7:0] ADDR_BT_CTRL    = 8'hDC;
  localparam logic [7:0] ADDR_STOP_UNLK  = 8'hF4;
  localparam logic [7:0] ADDR_OPTION     = 8'h80; // option bytes, read only
  localparam logic [7:0] ADDR_CPU_CMD    = 8'h84; // opcode issue port
  localparam logic [7:0] ADDR_STATUS     = 8'h88;
  // system_clock_control fields
  localparam int         CLK_WAKE_BIT    = 7;
  localparam int         CLK_DIV_HI      = 4;
  localparam int         CLK_DIV_LO      = 3;
  localparam logic [7:0] CLK_CTRL_RESET  = 8'h80;
  localparam logic [7:0] CLK_CTRL_MASK   = 8'h98;
  // divider codes
  localparam logic [1:0] DIV_16          = 2'h0;
  localparam logic [1:0] DIV_8           = 2'h1;
  localparam logic [1:0] DIV_2           = 2'h2;
  localparam logic [1:0] DIV_1           = 2'h3;
  // basic timer control
  localparam logic [3:0] WDT_OFF_KEY     = 4'hA;
  localparam logic [7:0] BT_CTRL_RESET   = 8'h00;
  // stop unlock key and opcodes
  localparam logic [7:0] STOP_KEY        = 8'hA5;
  localparam logic [7:0] OP_STOP         = 8'h7F;
  localparam logic [7:0] OP_IDLE         = 8'h6F;
  // oscillator source option
  localparam logic [1:0] SRC_INT_RC_FAST = 2'h0;
  localparam logic [1:0] SRC_INT_RC_SLOW = 2'h1;
  localparam logic [1:0] SRC_EXT_RC      = 2'h2;
  localparam logic [1:0] SRC_XTAL        = 2'h3;
  localparam int         RESET_VEC       = 16'h0100;
  // power states
  typedef enum logic [1:0] {CRPC_RUN, CRPC_IDLE, CRPC_STOP, CRPC_WAKE} crpc_state_t;
endpackage

// ==== crpc_sync.sv ====
// crpc_sync: two-flop synchroniser for a level
// assumes: one aclk domain, synchronous active-low reset
`timescale 1ns/100ps
module crpc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic d,
  output logic      q
);
  logic meta_reg;
  // first flop read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ==== crpc_top.sv ====
// crpc_top: clock select, cpu clock divider, stop/idle gating and reset gathering
// assumes: AXI4-Lite master on aclk; pins and option bits arrive synchronous to aclk
// Functional notes
// R1 - main clock source chosen from a two-bit non-volatile option field
// R2 - internal oscillator selected: both oscillator pins released as plain I/O
// R3 - internal RC runs at 3.2 MHz or 0.5 MHz per option
// R4 - with external oscillator, software sets oscillator pin port bits as outputs
// R5 - stop halts oscillator, CPU and peripherals; registers kept
// R6 - stop left only by reset or filtered external interrupt, if enabled
// R7 - idle gates clock to CPU only; timers and interrupt logic keep running
// R8 - idle left by reset or any enabled interrupt
// R9 - clock control register at D4H, bit 7 enables stop wake by interrupt
// R10 - bits 4:3 select CPU clock: undivided, /2, /8 or /16
// R11 - after reset, wake enabled and /16 selected
// R12 - option bit selects internal low-voltage or external pin reset
// R13 - reset from power-on, pin, watchdog or low-voltage detector
// R14 - reset pin passes input stage then synchronised before use
// R15 - external driver holds reset pin low through stabilisation time
// R16 - reset pin low loads all control registers with defaults
// R17 - watchdog overflow without refresh raises internal reset
// R18 - low voltage holds static reset until supply recovers
// R19 - writing 1010B to basic timer upper nibble disables watchdog reset
// R20 - software programs stabilisation interval before stop; used on wake
// R21 - reset clears divider select bits to 00B, giving /16
// R22 - stop without unlock key loads reset address instead of stopping
// R23 - stop opcode decoded by CPU enters stop mode
// R24 - idle opcode decoded by CPU enters idle mode
// R25 - new divider applied only at a boundary of the slower clock
`timescale 1ns/100ps
module crpc_top #(
  parameter int WDT_BITS = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // option bytes, pins and events
  input  wire logic [1:0]  osc_src_opt,
  input  wire logic        int_reset_opt,
  input  wire logic        power_on_rst,
  input  wire logic        reset_pin_low,
  input  wire logic        low_voltage_detector,
  input  wire logic        bt_overflow,
  input  wire logic [1:0]  filtered_external_irqs,
  input  wire logic        any_enabled_irq,
  input  wire logic        bt_stable_done,
  // outputs
  output logic             osc_enable,
  output logic             osc_pins_gpio,
  output logic             int_rc_slow,
  output logic             reset_pin_gpio,
  output logic             sys_reset,
  output logic             load_reset_vec,
  output logic             bt_restart,
  output logic             cpu_clk_en,
  output logic             periph_clk_en
);
  logic [7:0] clk_ctrl_reg;
  logic [7:0] bt_ctrl_reg;
  logic [7:0] stop_unlk_reg;
  logic [1:0] div_act_reg;
  logic [3:0] div_cnt_reg;
  logic       pin_sync;
  logic       aw_done_reg, w_done_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic       vec_reg;
  logic       op_wr;
  logic       sw_rst;
  logic       wdt_rst;
  crpc_pkg::crpc_state_t state_reg;

  // reset pin conditioning [R14]
  crpc_sync #(.RST_VAL(1'b1)) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (reset_pin_low | int_reset_opt),                     // pin high means no reset
    .q       (pin_sync)
  );

  // gather reset sources [R13] [R12] [R17] [R18] [R19]
  assign wdt_rst   = bt_overflow && (bt_ctrl_reg[7:4] != crpc_pkg::WDT_OFF_KEY);
  assign sw_rst    = power_on_rst || !pin_sync || wdt_rst ||
                     (int_reset_opt && low_voltage_detector);
  assign sys_reset = sw_rst;
  assign reset_pin_gpio = int_reset_opt;                            // [R12]

  // oscillator source handling [R1] [R2] [R3]
  assign osc_pins_gpio = (osc_src_opt == crpc_pkg::SRC_INT_RC_FAST) ||
                         (osc_src_opt == crpc_pkg::SRC_INT_RC_SLOW);
  assign int_rc_slow   = (osc_src_opt == crpc_pkg::SRC_INT_RC_SLOW);

  // AXI write channel capture, either order
  assign s_axi_awready = !aw_done_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_done_reg && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_done_reg <= 1'b0;
      w_done_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_done_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_done_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (aw_done_reg && w_done_reg) begin
        aw_done_reg  <= 1'b0;
        w_done_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_reg == crpc_pkg::ADDR_CLK_CTRL  ||
                         awaddr_reg == crpc_pkg::ADDR_BT_CTRL   ||
                         awaddr_reg == crpc_pkg::ADDR_STOP_UNLK ||
                         awaddr_reg == crpc_pkg::ADDR_CPU_CMD) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign op_wr = aw_done_reg && w_done_reg && wstrb_reg[0];

  // control registers, defaults on any reset [R9] [R11] [R16] [R21]
  always_ff @(posedge aclk) begin
    if (!aresetn || sw_rst) begin
      clk_ctrl_reg  <= crpc_pkg::CLK_CTRL_RESET;
      bt_ctrl_reg   <= crpc_pkg::BT_CTRL_RESET;
      stop_unlk_reg <= 8'h00;
    end else if (op_wr) begin
      if (awaddr_reg == crpc_pkg::ADDR_CLK_CTRL)
        clk_ctrl_reg <= wdata_reg[7:0] & crpc_pkg::CLK_CTRL_MASK;
      if (awaddr_reg == crpc_pkg::ADDR_BT_CTRL)
        bt_ctrl_reg <= wdata_reg[7:0];                              // [R19] [R20]
      if (awaddr_reg == crpc_pkg::ADDR_STOP_UNLK)
        stop_unlk_reg <= wdata_reg[7:0];
    end
  end

  // power state machine [R5] [R6] [R7] [R8] [R22] [R23] [R24]
  always_ff @(posedge aclk) begin
    if (!aresetn || sw_rst) begin
      state_reg <= crpc_pkg::CRPC_WAKE;                              // stabilise after reset
      vec_reg   <= 1'b0;
    end else begin
      vec_reg <= 1'b0;
      case (state_reg)
        crpc_pkg::CRPC_RUN: begin
          if (op_wr && awaddr_reg == crpc_pkg::ADDR_CPU_CMD) begin
            if (wdata_reg[7:0] == crpc_pkg::OP_STOP) begin
              if (stop_unlk_reg == crpc_pkg::STOP_KEY)
                state_reg <= crpc_pkg::CRPC_STOP;                    // [R23]
              else
                vec_reg <= 1'b1;                                     // [R22]
            end else if (wdata_reg[7:0] == crpc_pkg::OP_IDLE) begin
              state_reg <= crpc_pkg::CRPC_IDLE;                      // [R24]
            end
          end
        end
        crpc_pkg::CRPC_IDLE: begin
          if (any_enabled_irq)
            state_reg <= crpc_pkg::CRPC_RUN;                         // [R8]
        end
        crpc_pkg::CRPC_STOP: begin
          if (clk_ctrl_reg[crpc_pkg::CLK_WAKE_BIT] && |filtered_external_irqs)
            state_reg <= crpc_pkg::CRPC_WAKE;                        // [R6]
        end
        crpc_pkg::CRPC_WAKE: begin
          if (bt_stable_done)
            state_reg <= crpc_pkg::CRPC_RUN;                         // [R20]
        end
        default: state_reg <= crpc_pkg::CRPC_RUN;
      endcase
    end
  end
  assign load_reset_vec = vec_reg;
  assign osc_enable     = (state_reg != crpc_pkg::CRPC_STOP);        // [R5]
  assign bt_restart     = (state_reg == crpc_pkg::CRPC_STOP);

  // divider with glitch-free change at /16 boundary [R10] [R25]
  always_ff @(posedge aclk) begin
    if (!aresetn || sw_rst) begin
      div_cnt_reg <= 4'h0;
      div_act_reg <= crpc_pkg::DIV_16;                               // [R21]
    end else if (osc_enable) begin
      div_cnt_reg <= div_cnt_reg + 4'h1;
      if (div_cnt_reg == 4'hF)
        div_act_reg <= clk_ctrl_reg[crpc_pkg::CLK_DIV_HI:crpc_pkg::CLK_DIV_LO];
    end
  end

  // cpu enable gated in idle and stop [R7]
  always_comb begin
    case (div_act_reg)
      crpc_pkg::DIV_1:  cpu_clk_en = 1'b1;
      crpc_pkg::DIV_2:  cpu_clk_en = (div_cnt_reg[0] == 1'b1);
      crpc_pkg::DIV_8:  cpu_clk_en = (div_cnt_reg[2:0] == 3'h7);
      default:          cpu_clk_en = (div_cnt_reg == 4'hF);
    endcase
    if (state_reg != crpc_pkg::CRPC_RUN)
      cpu_clk_en = 1'b0;
  end
  assign periph_clk_en = osc_enable;                                 // [R7]

  // AXI read channel
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'h0;
      case (s_axi_araddr)
        crpc_pkg::ADDR_CLK_CTRL:  s_axi_rdata <= {24'h0, clk_ctrl_reg};
        crpc_pkg::ADDR_BT_CTRL:   s_axi_rdata <= {24'h0, bt_ctrl_reg};
        crpc_pkg::ADDR_STOP_UNLK: s_axi_rdata <= {24'h0, stop_unlk_reg};
        crpc_pkg::ADDR_OPTION:    s_axi_rdata <= {29'h0, int_reset_opt, osc_src_opt};
        crpc_pkg::ADDR_STATUS:    s_axi_rdata <= {28'h0, div_act_reg, state_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  chk_stop_wake: assert property (@(posedge aclk) disable iff (!aresetn || sw_rst) // [R6]
    state_reg == crpc_pkg::CRPC_STOP && !clk_ctrl_reg[crpc_pkg::CLK_WAKE_BIT]
    |=> state_reg == crpc_pkg::CRPC_STOP) else $error("stop left without wake");
  chk_idle_cpu: assert property (@(posedge aclk) disable iff (!aresetn) // [R7]
    state_reg == crpc_pkg::CRPC_IDLE |-> !cpu_clk_en && periph_clk_en)
    else $error("idle gating wrong");
  chk_stop_osc: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == crpc_pkg::CRPC_STOP |-> !osc_enable) else $error("osc runs in stop"); // [R5]
  chk_reset_div: assert property (@(posedge aclk) disable iff (!aresetn) // [R21]
    sw_rst |=> div_act_reg == crpc_pkg::DIV_16 && clk_ctrl_reg == crpc_pkg::CLK_CTRL_RESET)
    else $error("reset defaults wrong");
  chk_div_edge: assert property (@(posedge aclk) disable iff (!aresetn || sw_rst)
    div_act_reg != $past(div_act_reg) |-> div_cnt_reg == 4'h0) else $error("div glitch"); // [R25]
  chk_wdt_off: assert property (@(posedge aclk) disable iff (!aresetn) // [R19]
    bt_ctrl_reg[7:4] == crpc_pkg::WDT_OFF_KEY && !power_on_rst && pin_sync &&
    !(int_reset_opt && low_voltage_detector) |-> !sys_reset) else $error("wdt not off");
  chk_lvr_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [R18]
    int_reset_opt && low_voltage_detector |-> sys_reset) else $error("lvr no reset");
  chk_bad_stop: assert property (@(posedge aclk) disable iff (!aresetn || sw_rst) // [R22]
    state_reg == crpc_pkg::CRPC_RUN && op_wr && awaddr_reg == crpc_pkg::ADDR_CPU_CMD &&
    wdata_reg[7:0] == crpc_pkg::OP_STOP && stop_unlk_reg != crpc_pkg::STOP_KEY
    |=> load_reset_vec && state_reg == crpc_pkg::CRPC_RUN) else $error("bad stop");

  // named steps of the power-down paths
  sequence s_idle_cmd;
    state_reg == crpc_pkg::CRPC_RUN && op_wr && awaddr_reg == crpc_pkg::ADDR_CPU_CMD &&
    wdata_reg[7:0] == crpc_pkg::OP_IDLE;
  endsequence
  // stop opcode with the unlock key in place
  sequence s_keyed_stop;
    state_reg == crpc_pkg::CRPC_RUN && op_wr && awaddr_reg == crpc_pkg::ADDR_CPU_CMD &&
    wdata_reg[7:0] == crpc_pkg::OP_STOP && stop_unlk_reg == crpc_pkg::STOP_KEY;
  endsequence
  // filtered interrupt while stopped with wake enabled
  sequence s_irq_wake;
    state_reg == crpc_pkg::CRPC_STOP && clk_ctrl_reg[crpc_pkg::CLK_WAKE_BIT] &&
    |filtered_external_irqs;
  endsequence
  // stabilisation interval over while waking
  sequence s_settle;
    state_reg == crpc_pkg::CRPC_WAKE && bt_stable_done;
  endsequence

  // power-down entry and exit steps
  chk_idle_entry: assert property (@(posedge aclk) disable iff (!aresetn || sw_rst) // [R24]
    s_idle_cmd |=> state_reg == crpc_pkg::CRPC_IDLE && !cpu_clk_en)
    else $error("idle not entered");
  chk_stop_entry: assert property (@(posedge aclk) disable iff (!aresetn || sw_rst) // [R23]
    s_keyed_stop |=> state_reg == crpc_pkg::CRPC_STOP && !osc_enable && !load_reset_vec)
    else $error("stop not entered");
  chk_irq_wake: assert property (@(posedge aclk) disable iff (!aresetn || sw_rst) // [R6]
    s_irq_wake |=> state_reg == crpc_pkg::CRPC_WAKE && osc_enable)
    else $error("stop not left on irq");
  chk_wake_run: assert property (@(posedge aclk) disable iff (!aresetn || sw_rst) // [R20]
    s_settle |=> state_reg == crpc_pkg::CRPC_RUN)
    else $error("wake did not finish");
endmodule

// ==== tb_top.sv ====
// tb_top: self-checking bench for the clock, reset and power-down controller
// assumes: crpc_pkg, crpc_sync, crpc_top and crpc_partner are compiled first
`timescale 1ns/100ps
module tb_top;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, iro, por, pin_low, lvd, bto, any_irq;
  logic        stable, osc_en, pins_gpio, rc_slow, pin_gpio, sys_reset, load_vec;
  logic        bt_restart, cpu_en, periph_en, pin_req;
  logic [7:0]  awaddr, araddr, m_clk, v;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp, src, irqs;
  int          err_count, checks_done, rst_cnt, vec_cnt, k, n, j;
  int          divs[4] = '{16, 8, 2, 1};

  crpc_top #(.WDT_BITS(8)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .osc_src_opt(src), .int_reset_opt(iro), .power_on_rst(por), .reset_pin_low(pin_low),
    .low_voltage_detector(lvd), .bt_overflow(bto), .filtered_external_irqs(irqs),
    .any_enabled_irq(any_irq), .bt_stable_done(stable), .osc_enable(osc_en),
    .osc_pins_gpio(pins_gpio), .int_rc_slow(rc_slow), .reset_pin_gpio(pin_gpio),
    .sys_reset(sys_reset), .load_reset_vec(load_vec), .bt_restart(bt_restart),
    .cpu_clk_en(cpu_en), .periph_clk_en(periph_en));
  crpc_partner #(.STAB(16)) u_far (.aclk(aclk), .osc_enable(osc_en), .pin_req(pin_req),
    .reset_pin_low(pin_low), .bt_stable_done(stable));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // count one-cycle reset and reset-vector pulses so short ones are not missed
  always @(posedge aclk) begin
    rst_cnt <= rst_cnt + (sys_reset === 1'b1);
    vec_cnt <= vec_cnt + (load_vec === 1'b1);
  end
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one bus access; d is write data, or the expected data of a read
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    logic aw_p, w_p, ar_p;
    aw_p = w;
    w_p = w;
    ar_p = !w;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h0, d};
    {awvalid, wvalid, bready} <= {3{w}};
    {arvalid, rready} <= {2{!w}};
    // each request is held until its own ready, then the answer is awaited
    while ((aw_p || w_p || ar_p || !(w ? bvalid : rvalid)) && n < 200) begin
      @(posedge aclk);
      n++;
      aw_p &= !awready;
      w_p &= !wready;
      ar_p &= !arready;
      if (!aw_p) awvalid <= 1'b0;
      if (!w_p) wvalid <= 1'b0;
      if (!ar_p) arvalid <= 1'b0;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    if (n >= 200) chk(0, 1, "bus timeout");
    chk({30'h0, w ? bresp : rresp}, {30'h0, er}, "response");
    if (!w && er == 2'h0) chk(rdata, {24'h0, d}, "read data");
  endtask
  // count cpu clock enables over a window
  task automatic cnt_en(input int cyc);
    k = 0;
    repeat (cyc) begin
      @(posedge aclk);
      k += (cpu_en === 1'b1);
    end
  endtask
  // pulse one reset source (0 low voltage, 1 watchdog, 2 power-on) and see if reset came
  task automatic kick(input int s, input int hold, input logic exp);
    j = rst_cnt;
    {por, bto, lvd} <= 3'(1 << s);
    repeat (hold) @(posedge aclk);
    if (hold > 8) chk(sys_reset, exp, "reset held");
    {por, bto, lvd} <= 3'h0;
    repeat (3) @(posedge aclk);
    chk(rst_cnt > j, exp, "reset source");
    repeat (40) @(posedge aclk);
  endtask
  // verdict
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // cut a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    results();
  end
  // main sequence
  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, iro, por, bto, any_irq, lvd, pin_req} = '0;
    {awaddr, araddr, wdata, irqs} = '0;
    src = 2'h3;
    void'($urandom(24786));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (40) @(posedge aclk);
    bus(0, crpc_pkg::ADDR_CLK_CTRL, 8'h80, 2'h0);
    bus(0, crpc_pkg::ADDR_STATUS, 8'h00, 2'h0);
    bus(0, 8'h90, 8'h00, 2'h2);
    bus(1, 8'h90, 8'h5A, 2'h2);
    $display("reset values done");
    for (int c = 0; c < 4; c++) begin
      v = 8'($urandom) & 8'hE7 | 8'(c << 3);
      m_clk = v & 8'h98;
      bus(1, crpc_pkg::ADDR_CLK_CTRL, v, 2'h0);
      bus(0, crpc_pkg::ADDR_CLK_CTRL, m_clk, 2'h0);
      repeat (32) @(posedge aclk);
      cnt_en(64);
      chk(k, 64 / divs[c], "cpu clock rate");
    end
    $display("divider done");
    for (int s = 0; s < 8; s++) begin
      src <= 2'(s);
      iro <= s[2];
      repeat (2) @(posedge aclk);
      chk(pins_gpio, s % 4 < 2, "pins released");
      chk(rc_slow, s % 4 == 1, "slow rc");
      chk(pin_gpio, s[2], "reset pin gpio");
    end
    src <= 2'h3;
    iro <= 1'b0;
    $display("options done");
    m_clk = 8'h18;
    bus(1, crpc_pkg::ADDR_CLK_CTRL, m_clk, 2'h0);
    bus(1, crpc_pkg::ADDR_CPU_CMD, crpc_pkg::OP_IDLE, 2'h0);
    cnt_en(32);
    chk(k, 0, "idle cpu clock");
    chk(periph_en, 1, "idle timer clock");
    bus(0, crpc_pkg::ADDR_STATUS, {4'h0, m_clk[4:3], 2'h1}, 2'h0);
    any_irq <= 1'b1;
    repeat (3) @(posedge aclk);
    any_irq <= 1'b0;
    bus(0, crpc_pkg::ADDR_STATUS, {4'h0, m_clk[4:3], 2'h0}, 2'h0);
    $display("idle done");
    j = vec_cnt;
    bus(1, crpc_pkg::ADDR_STOP_UNLK, 8'h00, 2'h0);
    bus(1, crpc_pkg::ADDR_CPU_CMD, crpc_pkg::OP_STOP, 2'h0);
    repeat (3) @(posedge aclk);
    chk(vec_cnt - j, 1, "reset vector load");
    chk(osc_en, 1, "no stop without key");
    bus(1, crpc_pkg::ADDR_STOP_UNLK, crpc_pkg::STOP_KEY, 2'h0);
    bus(1, crpc_pkg::ADDR_CPU_CMD, crpc_pkg::OP_STOP, 2'h0);
    cnt_en(8);
    chk(k, 0, "stop cpu clock");
    chk({osc_en, periph_en}, 0, "stop oscillator");
    irqs <= 2'h3;
    any_irq <= 1'b1;
    repeat (20) @(posedge aclk);
    chk(osc_en, 0, "wake disabled");
    {irqs, any_irq} <= '0;
    pin_req <= 1'b1;
    j = rst_cnt;
    @(posedge aclk);
    pin_req <= 1'b0;
    @(posedge aclk);
    chk(sys_reset, 0, "pin synchronised");
    repeat (4) @(posedge aclk);
    chk(rst_cnt > j, 1, "pin reset");
    repeat (60) @(posedge aclk);
    bus(0, crpc_pkg::ADDR_CLK_CTRL, 8'h80, 2'h0);
    bus(0, crpc_pkg::ADDR_STATUS, 8'h00, 2'h0);
    m_clk = 8'h90;
    bus(1, crpc_pkg::ADDR_CLK_CTRL, m_clk, 2'h0);
    repeat (16) @(posedge aclk); // new divider takes hold before stop freezes it
    bus(1, crpc_pkg::ADDR_STOP_UNLK, crpc_pkg::STOP_KEY, 2'h0);
    bus(1, crpc_pkg::ADDR_CPU_CMD, crpc_pkg::OP_STOP, 2'h0);
    any_irq <= 1'b1;
    repeat (10) @(posedge aclk);
    chk({osc_en, bt_restart}, 1, "other irq ignored");
    irqs <= 2'h2;
    repeat (3) @(posedge aclk);
    {irqs, any_irq} <= '0;
    chk(osc_en, 1, "wake by irq");
    bus(0, crpc_pkg::ADDR_STATUS, {4'h0, m_clk[4:3], 2'h3}, 2'h0);
    repeat (40) @(posedge aclk);
    bus(0, crpc_pkg::ADDR_STATUS, {4'h0, m_clk[4:3], 2'h0}, 2'h0);
    bus(0, crpc_pkg::ADDR_CLK_CTRL, m_clk, 2'h0);
    $display("stop done");
    kick(1, 1, 1'b1);
    bus(0, crpc_pkg::ADDR_CLK_CTRL, 8'h80, 2'h0);
    bus(1, crpc_pkg::ADDR_BT_CTRL, 8'hA0, 2'h0);
    kick(1, 1, 1'b0);
    kick(2, 3, 1'b1);
    kick(0, 5, 1'b0);
    iro <= 1'b1;
    kick(0, 30, 1'b1);
    bus(0, crpc_pkg::ADDR_STATUS, 8'h00, 2'h0);
    iro <= 1'b0;
    $display("reset sources done");
    results();
  end
endmodule
